// *** hw/adc_auto_trigger_sequencer.v ***
// Chosen here: the APB register port and the register addresses.
`default_nettype none

// Summary of operation
// R01: Arm rising edge clears overrun flag.
// R02: PWM edge starts blanking, then CH1.
// R03: Gap delay between CH1 and CH2.
// R04: After CH2, wait next PWM edge.
// R05: After N cycles, clear arm, set irq.
// R06: Trigger while busy sets overrun, ignored.
// R07: Ignored trigger needs fresh edge later.
// R08: Comparator mode needs select 01, count nonzero.
// R09: Comparator edge runs timer preload to full.
// R10: Overflow stops timer, starts conversion.
// R11: Group size 1, 2, 4, 8 or 16.
// R12: Software may clear arm on dead trigger.
// R13: No rearm until group is finished.
// R14: Software clears irq after arm cleared.
// R15: Manual single start reinitialises sequencer.
// R16: Completed group still raises irq on clear.
// R17: Comparator edge ignored when unarmed or disabled.
// R18: Edge while counting changes nothing.
// R19: After ignored edge, need new edge plus overflow.
// R20: Two-channel pair needs new edge and overflow.
// R21: Results accumulate across the group.
// R22: Blanking length is a five-bit field.
// R23: Clearing arm during blanking resets at once.
// R24: Gap only between CH1 end and CH2 start.
// R25: Codes 1..5 give 1,2,4,8,16.
// R26: Timer steps per prescaled tick, reloads.
module adc_auto_trigger_sequencer
(
    input wire I_CLOCK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output wire [31:0] O_PRDATA,
    output wire O_PREADY,
    output wire O_PSLVERR,
    input wire I_PWM_CHANNEL_ZERO_OUT,
    input wire I_PROTECT_COMPARATOR_OUT,
    input wire I_CONV_DONE,
    input wire [11:0] I_CONV_DATA,
    output reg O_CONV_START,
    output reg O_CONV_CHANNEL,
    output wire O_CONVERTER_BUSY_FLAG,
    output wire O_CONVERTER_IRQ_FLAG
);
`include "adc_seq_regs.vh"

    // ****************************************************************
    // Sequencer states.
    // ****************************************************************
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_BLANK = 7'h02;
    localparam [6:0] S_TIMER = 7'h04;
    localparam [6:0] S_CH1 = 7'h08;
    localparam [6:0] S_GAP = 7'h10;
    localparam [6:0] S_CH2 = 7'h20;
    localparam [6:0] S_MAN = 7'h40;

    reg [31:0] ctrl_r;
    reg [12:0] timing_r;
    reg [15:0] preload_r;
    reg [6:0] state_r;
    reg [6:0] state_nxt;
    reg ovr_r;
    reg run_r;
    reg irq_r;
    reg [4:0] done_r;
    reg [15:0] timer_r;
    reg [7:0] psc_r;
    reg [7:0] step_r;
    reg [4:0] delay_r;
    reg [31:0] acc_r;
    reg [31:0] rdata_r;
    reg pwm_s1_r;
    reg pwm_s2_r;
    reg pwm_d_r;
    reg cmp_s1_r;
    reg cmp_s2_r;
    reg cmp_d_r;
    reg arm_d_r;
    reg pend_irq_r;

    // Control and timing fields.
    wire arm = ctrl_r[`CTRL_ARM];
    wire two_ch = ctrl_r[`CTRL_TWO_CH];
    wire [1:0] trig = ctrl_r[`CTRL_TRIG_HI:`CTRL_TRIG_LO];
    wire [2:0] cnt = ctrl_r[`CTRL_CNT_HI:`CTRL_CNT_LO];
    wire ext_en = ctrl_r[`CTRL_EXT_EN];
    wire [4:0] leading_edge_blanking = timing_r[`TIM_LEB_HI:`TIM_LEB_LO];
    wire [3:0] gap = timing_r[`TIM_GAP_HI:`TIM_GAP_LO];

    wire pwm_rise = pwm_s2_r & ~pwm_d_r;
    wire cmp_rise = cmp_s2_r & ~cmp_d_r;
    wire arm_rise = arm & ~arm_d_r;
    wire busy = (state_r == S_CH1) | (state_r == S_CH2) |
        (state_r == S_MAN);
    wire cnt_ok = (cnt != `CNT_MANUAL) & (cnt <= `CNT_MAX_CODE); // R25
    wire pwm_mode = arm & cnt_ok & (trig == `TRIG_PWM);
    wire cmp_mode = arm & cnt_ok & (trig == `TRIG_CMP); // R08
    wire tick = (psc_r == ctrl_r[`CTRL_PSC_HI:`CTRL_PSC_LO]);
    wire step_tick = (step_r == `STEP_CYCLES - 8'h01);
    wire overflow = run_r & tick & (timer_r == `TIMER_FULL);

    // Group size N as a count of 1, 2, 4, 8 or 16.
    reg [4:0] group_n;
    always @*
    begin
        case (cnt) // R11
            3'h1: group_n = 5'h01;
            3'h2: group_n = 5'h02;
            3'h3: group_n = 5'h04;
            3'h4: group_n = 5'h08;
            default: group_n = 5'h10;
        endcase
    end

    wire last_conv = (done_r + 5'h01 == group_n);
    wire cycle_end = I_CONV_DONE & ((state_r == S_CH2) |
        ((state_r == S_CH1) & ~two_ch));

    // ****************************************************************
    // Trigger qualification.
    // ****************************************************************
    // Blanking and the channel gap count as work in progress, so a
    // trigger landing there is a retrigger as much as one mid-conversion.
    wire in_progress = busy | (state_r == S_BLANK) | (state_r == S_GAP);
    wire pwm_retrig = pwm_mode & pwm_rise & in_progress; // R06 R07
    // The timer may only be started from idle; an edge that finds a
    // conversion running is dropped and flagged.
    wire cmp_start = cmp_mode & ext_en & cmp_rise & ~run_r &
        (state_r == S_IDLE); // R09 R17 R19
    wire cmp_retrig = cmp_mode & ext_en & cmp_rise & ~run_r &
        in_progress; // R06 R19

    // ****************************************************************
    // Input synchronisers and edge detectors.
    // ****************************************************************
    always @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            pwm_s1_r <= 1'b0;
            pwm_s2_r <= 1'b0;
            pwm_d_r <= 1'b0;
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
            cmp_d_r <= 1'b0;
            arm_d_r <= 1'b0;
        end
        else
        begin
            pwm_s1_r <= I_PWM_CHANNEL_ZERO_OUT;
            pwm_s2_r <= pwm_s1_r;
            pwm_d_r <= pwm_s2_r;
            cmp_s1_r <= I_PROTECT_COMPARATOR_OUT;
            cmp_s2_r <= cmp_s1_r;
            cmp_d_r <= cmp_s2_r;
            // Arm history feeds the rising-edge clear of the overrun flag.
            arm_d_r <= arm;
        end
    end

    // ****************************************************************
    // Next state logic.
    // ****************************************************************
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:
            begin
                if (ctrl_r[`CTRL_START] & (cnt == `CNT_MANUAL))
                    state_nxt = S_MAN; // R15
                else if (pwm_mode & pwm_rise)
                    state_nxt = S_BLANK; // R02 R04 R07
                // Comparator mode skips blanking: overflow starts CH1.
                else if (cmp_mode & overflow)
                    state_nxt = S_CH1; // R10 R19 R20
            end
            S_BLANK:
            begin
                if (~arm)
                    state_nxt = S_IDLE; // R23
                else if (delay_r == 5'h00 && step_tick)
                    state_nxt = S_CH1; // R02 R22
            end
            S_CH1:
            begin
                // A one-channel cycle ends with CH1.
                if (I_CONV_DONE)
                    state_nxt = two_ch ? S_GAP : S_IDLE;
            end
            S_GAP:
            begin
                if (delay_r == 5'h00 && step_tick)
                    state_nxt = S_CH2; // R03 R24
            end
            S_CH2:
            begin
                if (I_CONV_DONE)
                    state_nxt = S_IDLE; // R04
            end
            S_MAN:
            begin
                if (I_CONV_DONE)
                    state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // ****************************************************************
    // State entry decode.
    // ****************************************************************
    // Start is raised on entry to a converting state, never while in it.
    wire enter_ch1 = (state_nxt == S_CH1) & (state_r != S_CH1);
    wire enter_ch2 = (state_nxt == S_CH2) & (state_r != S_CH2);
    wire enter_man = (state_nxt == S_MAN) & (state_r != S_MAN);
    wire enter_blank = (state_nxt == S_BLANK) & (state_r != S_BLANK);
    wire enter_gap = (state_nxt == S_GAP) & (state_r != S_GAP);

    // ****************************************************************
    // Sequencer, timer and accumulator.
    // ****************************************************************
    always @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            state_r <= S_IDLE;
            ovr_r <= 1'b0;
            run_r <= 1'b0;
            done_r <= 5'h00;
            timer_r <= 16'h0000;
            psc_r <= 8'h00;
            step_r <= 8'h00;
            delay_r <= 5'h00;
            acc_r <= 32'h0000_0000;
            O_CONV_START <= 1'b0;
            O_CONV_CHANNEL <= 1'b0;
            pend_irq_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            O_CONV_START <= enter_ch1 | enter_ch2 | enter_man;
            if (state_nxt == S_CH2)
                O_CONV_CHANNEL <= 1'b1;
            else if (state_nxt == S_CH1)
                O_CONV_CHANNEL <= 1'b0;
            // Prescaler and step counters run free; delays end on a step.
            psc_r <= tick ? 8'h00 : psc_r + 8'h01;
            step_r <= step_tick ? 8'h00 : step_r + 8'h01;
            if (enter_blank)
                delay_r <= leading_edge_blanking; // R22
            else if (enter_gap)
                delay_r <= {1'b0, gap}; // R03
            else if (step_tick && delay_r != 5'h00)
                delay_r <= delay_r - 5'h01;
            if (arm_rise)
                ovr_r <= 1'b0; // R01
            else if (pwm_retrig | cmp_retrig)
                ovr_r <= 1'b1; // R06
            // Timer starts only when idle-armed and stopped.
            if (overflow)
            begin
                run_r <= 1'b0; // R10
                timer_r <= preload_r; // R26
            end
            else if (~cmp_mode)
            begin
                run_r <= 1'b0;
                timer_r <= preload_r;
            end
            else if (cmp_start)
            begin
                run_r <= 1'b1; // R09 R17 R18
                timer_r <= preload_r;
            end
            else if (run_r & tick)
                timer_r <= timer_r + 16'h0001; // R09 R26
            // The sum stands until the next arm or manual start.
            if (arm_rise | state_r == S_MAN)
            begin
                done_r <= 5'h00; // R15
                acc_r <= 32'h0000_0000;
            end
            else if (I_CONV_DONE & busy)
                acc_r <= acc_r + {20'h00000, I_CONV_DATA}; // R21
            // The done count stops at N so a finished group reads whole.
            if (cycle_end & arm & ~last_conv)
                done_r <= done_r + 5'h01; // R13
            else if (cycle_end & last_conv)
                done_r <= group_n;
            // Group completion after software clear still flags.
            pend_irq_r <= cycle_end & last_conv & ~arm; // R16
        end
    end

    // ****************************************************************
    // APB register slave.
    // ****************************************************************
    wire wr = I_PSEL & I_PENABLE & I_PWRITE;
    wire rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
    // Unmapped addresses answer with an error in the access phase.
    wire mapped = (I_PADDR == `ADDR_CTRL) | (I_PADDR == `ADDR_TIMING) |
        (I_PADDR == `ADDR_PRELOAD) | (I_PADDR == `ADDR_STATUS) |
        (I_PADDR == `ADDR_RESULT);
    wire group_done = cycle_end & last_conv;
    wire manual_done = (state_r == S_MAN) & I_CONV_DONE;

    always @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            ctrl_r <= `CTRL_RESET;
            timing_r <= 13'h0000;
            preload_r <= 16'h0000;
            irq_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            // Start is a level, acted on only while idle in manual mode.
            if (wr && I_PADDR == `ADDR_CTRL)
            begin
                // Setting arm is ignored while a group is running; a write clearing arm always takes.
                ctrl_r[`CTRL_PSC_HI:`CTRL_TWO_CH] <=
                    I_PWDATA[`CTRL_PSC_HI:`CTRL_TWO_CH];
                ctrl_r[`CTRL_START] <= I_PWDATA[`CTRL_START];
                if (~arm | ~I_PWDATA[`CTRL_ARM])
                    ctrl_r[`CTRL_ARM] <= I_PWDATA[`CTRL_ARM]; // R12 R13
            end
            if (group_done & arm)
                ctrl_r[`CTRL_ARM] <= 1'b0; // R05
            if (group_done | pend_irq_r | manual_done)
                irq_r <= 1'b1; // R05 R16
            else if (wr && I_PADDR == `ADDR_STATUS &&
                I_PWDATA[`ST_IRQ])
                irq_r <= 1'b0; // R14
            if (wr && I_PADDR == `ADDR_TIMING)
                timing_r <= I_PWDATA[12:0];
            // Preload is locked while the timer runs, so a count holds.
            if (wr && I_PADDR == `ADDR_PRELOAD && ~run_r)
                preload_r <= I_PWDATA[15:0];
            if (rd)
            begin
                case (I_PADDR)
                    `ADDR_CTRL: rdata_r <= ctrl_r;
                    `ADDR_TIMING: rdata_r <= {19'h00000, timing_r};
                    `ADDR_PRELOAD: rdata_r <= {16'h0000, preload_r};
                    `ADDR_STATUS: rdata_r <= {19'h00000, done_r,
                        4'h0, irq_r, busy, run_r, ovr_r};
                    `ADDR_RESULT: rdata_r <= acc_r;
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign O_PRDATA = rdata_r;
    // The slave never inserts wait states.
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
    assign O_CONVERTER_BUSY_FLAG = busy;
    assign O_CONVERTER_IRQ_FLAG = irq_r;

endmodule // adc_auto_trigger_sequencer

`default_nettype wire

// *** hw/adc_seq_regs.vh ***
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH
// Register byte addresses.
`define ADDR_CTRL 12'h000
`define ADDR_TIMING 12'h004
`define ADDR_PRELOAD 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_RESULT 12'h010
// Control register fields.
`define CTRL_ARM 0
`define CTRL_TWO_CH 1
`define CTRL_TRIG_LO 2
`define CTRL_TRIG_HI 3
`define CTRL_CNT_LO 4
`define CTRL_CNT_HI 6
`define CTRL_EXT_EN 7
`define CTRL_PSC_LO 8
`define CTRL_PSC_HI 15
`define CTRL_START 16
`define CTRL_IRQ 17
`define CTRL_RESET 32'h0000_0000
// Timing register fields.
`define TIM_LEB_LO 0
`define TIM_LEB_HI 4
`define TIM_GAP_LO 8
`define TIM_GAP_HI 11
// Status register fields.
`define ST_OVR 0
`define ST_RUN 1
`define ST_BUSY 2
`define ST_IRQ 3
`define ST_DONE_LO 8
`define ST_DONE_HI 12
// Trigger select codes and count codes.
`define TRIG_PWM 2'h0
`define TRIG_CMP 2'h1
`define CNT_MANUAL 3'h0
`define CNT_MAX_CODE 3'h5
`define TIMER_FULL 16'hffff
// Blanking and gap unit, in cycles per step.
`define STEP_CYCLES 8'h10
`endif

// *** sim/seq_chk_sva.sv ***
`default_nettype none
// ******************************
// Sequencer port checker
// ******************************
module seq_chk
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic I_CONV_DONE,
    input wire logic O_CONV_START,
    input wire logic O_CONV_CHANNEL,
    input wire logic O_CONVERTER_BUSY_FLAG,
    input wire logic O_CONVERTER_IRQ_FLAG
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic wr = I_PSEL & I_PENABLE & I_PWRITE;
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);
    chk_busy_start: assert property (
        $rose(O_CONVERTER_BUSY_FLAG) |-> O_CONV_START)
        else $error("no start after busy rise");
    chk_start_pulse: assert property (
        O_CONV_START |=> !O_CONV_START)
        else $error("start longer than one cycle");
    chk_start_busy: assert property (
        O_CONV_START |-> O_CONVERTER_BUSY_FLAG)
        else $error("start while not busy");
    chk_busy_done: assert property (
        $fell(O_CONVERTER_BUSY_FLAG) |-> $past(I_CONV_DONE))
        else $error("busy dropped without done");
    chk_busy_hold: assert property (
        O_CONVERTER_BUSY_FLAG && !I_CONV_DONE |=> O_CONVERTER_BUSY_FLAG)
        else $error("conversion abandoned");
    chk_done_idle: assert property (
        I_CONV_DONE && O_CONVERTER_BUSY_FLAG |=> !O_CONVERTER_BUSY_FLAG)
        else $error("no gap after done");
    chk_irq_cause: assert property (
        $rose(O_CONVERTER_IRQ_FLAG) |-> $past(I_CONV_DONE)
        || $past(I_CONV_DONE, 2) || $past(wr))
        else $error("irq without cause");
    chk_irq_hold: assert property (
        O_CONVERTER_IRQ_FLAG && !wr |=> O_CONVERTER_IRQ_FLAG)
        else $error("irq lost");
    cover property (O_CONV_START && O_CONV_CHANNEL);
    cover property (I_CONV_DONE && !O_CONV_CHANNEL);
    cover property ($rose(O_CONVERTER_IRQ_FLAG));
endmodule // seq_chk
bind adc_auto_trigger_sequencer seq_chk i_seq_chk (.*);
`default_nettype wire

// *** sim/conv_model.sv ***
`default_nettype none
// ******************************
// Converter core model
// ******************************
module conv_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] lat,
    output logic done = 1'b0,
    output logic [11:0] data = 12'h000
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Data toggles outside the done pulse, so after a done it holds 0a5 only on alternate cycles.
    always @(posedge clk)
    begin
        done <= 1'b0;
        data <= ~data;
        if (rst)
            cnt <= 0;
        else if (start)
            cnt <= lat;
        else if (cnt == 1)
        begin
            done <= 1'b1;
            data <= 12'h0a5;
            cnt <= 0;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule // conv_model
`default_nettype wire

// *** sim/testbench.sv ***
`default_nettype none
`include "adc_seq_regs.vh"
// ******************************
// Sequencer testbench
// ******************************
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_CLOCK = 1'b0;
    logic I_RST = 1'b1;
    logic I_PSEL = 1'b0;
    logic I_PENABLE = 1'b0;
    logic I_PWRITE = 1'b0;
    logic [11:0] I_PADDR = 12'h000;
    logic [31:0] I_PWDATA = 32'h0;
    logic I_PWM_CHANNEL_ZERO_OUT = 1'b0;
    logic I_PROTECT_COMPARATOR_OUT = 1'b0;
    logic [7:0] lat = 8'h04;
    wire logic [31:0] O_PRDATA;
    wire logic [11:0] I_CONV_DATA;
    wire logic O_PREADY, O_PSLVERR, I_CONV_DONE, O_CONV_START;
    wire logic O_CONV_CHANNEL, O_CONVERTER_BUSY_FLAG, O_CONVERTER_IRQ_FLAG;
    logic [31:0] q;
    logic err;
    logic st_ch [64];
    int st_cyc [64];
    int mismatches = 0;
    int n_tests = 0;
    int starts = 0;
    int cyc = 0;
    adc_auto_trigger_sequencer i_adc_auto_trigger_sequencer (.*);
    conv_model i_conv_model (.clk(I_CLOCK), .rst(I_RST), .lat(lat),
        .start(O_CONV_START), .done(I_CONV_DONE), .data(I_CONV_DATA));
    initial
    begin
        forever #5 I_CLOCK = ~I_CLOCK;
    end
    always @(posedge I_CLOCK)
    begin
        cyc <= cyc + 1;
        if (O_CONV_START === 1'b1)
        begin
            st_cyc[starts & 63] <= cyc;
            st_ch[starts & 63] <= O_CONV_CHANNEL;
            starts <= starts + 1;
        end
    end
    task w(input int n);
        repeat (n) @(posedge I_CLOCK);
    endtask
    task check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic wn, input logic [11:0] a, input logic [31:0] d);
        w(1);
        I_PSEL <= 1'b1;
        I_PWRITE <= wn;
        I_PADDR <= a;
        I_PWDATA <= d;
        w(1);
        I_PENABLE <= 1'b1;
        do
            w(1);
        while (O_PREADY !== 1'b1);
        q = O_PRDATA;
        err = O_PSLVERR;
        I_PSEL <= 1'b0;
        I_PENABLE <= 1'b0;
    endtask
    function logic [31:0] cw(input logic a, t, input logic [1:0] s,
        input logic [2:0] n, input logic e);
        cw = {24'h0, e, n, s, t, a};
    endfunction
    task arm(input logic t, input logic [1:0] s, input logic [2:0] n);
        apb(1'b1, `ADDR_STATUS, 32'h8);
        apb(1'b1, `ADDR_CTRL, cw(1'b0, t, s, n, 1'b0));
        apb(1'b1, `ADDR_CTRL, cw(1'b1, t, s, n, 1'b0));
    endtask
    task pin(input logic c);
        w(1);
        if (c)
            I_PROTECT_COMPARATOR_OUT <= 1'b1;
        else
            I_PWM_CHANNEL_ZERO_OUT <= 1'b1;
        w(4);
        I_PROTECT_COMPARATOR_OUT <= 1'b0;
        I_PWM_CHANNEL_ZERO_OUT <= 1'b0;
    endtask
    task t_reset;
        apb(1'b0, `ADDR_CTRL, 32'h0);
        check("ctrl", q, `CTRL_RESET);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("status", q, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", q, 32'h0);
        check("slverr", err, 1'b1);
        $display("test reset done");
    endtask
    task t_groups;
        int b;
        for (int c = 1; c <= 5; c++)
        begin
            b = starts;
            arm(1'b0, `TRIG_PWM, 3'(c));
            for (int k = 0; k < 20 && O_CONVERTER_IRQ_FLAG !== 1'b1; k++)
            begin
                pin(1'b0);
                w(40);
            end
            check("group", starts - b, 1 << (c - 1));
            apb(1'b0, `ADDR_CTRL, 32'h0);
            check("arm", q[`CTRL_ARM], 1'b0);
            apb(1'b0, `ADDR_RESULT, 32'h0);
            check("sum", q, 32'h0a5 << (c - 1));
        end
        $display("test groups done");
    endtask
    task t_overrun;
        int b;
        lat <= 8'h3c;
        b = starts;
        arm(1'b0, `TRIG_PWM, 3'h2);
        pin(1'b0);
        w(30);
        pin(1'b0);
        w(100);
        check("ignored", starts - b, 1);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("ovr", q[`ST_OVR], 1'b1);
        pin(1'b0);
        w(100);
        check("n", starts - b, 2);
        check("irq", O_CONVERTER_IRQ_FLAG, 1'b1);
        arm(1'b0, `TRIG_PWM, 3'h2);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("ovr clr", q[`ST_OVR], 1'b0);
        apb(1'b1, `ADDR_TIMING, 32'h1f);
        b = starts;
        pin(1'b0);
        apb(1'b1, `ADDR_CTRL, 32'h0);
        w(600);
        check("abort", starts - b, 0);
        lat <= 8'h04;
        $display("test overrun done");
    endtask
    task t_two;
        int b;
        int d;
        apb(1'b1, `ADDR_TIMING, 32'h200);
        b = starts;
        arm(1'b1, `TRIG_PWM, 3'h2);
        pin(1'b0);
        w(150);
        check("pair", starts - b, 2);
        check("ch1", st_ch[b & 63], 1'b0);
        check("ch2", st_ch[(b + 1) & 63], 1'b1);
        d = st_cyc[(b + 1) & 63] - st_cyc[b & 63];
        check("gap", d >= 38 && d <= 60, 1'b1);
        pin(1'b0);
        w(150);
        check("pair2", starts - b, 4);
        $display("test two channel done");
    endtask
    task t_cmp;
        int b;
        apb(1'b1, `ADDR_TIMING, 32'h0);
        apb(1'b1, `ADDR_PRELOAD, 32'hffc0);
        b = starts;
        arm(1'b0, `TRIG_CMP, 3'h1);
        pin(1'b1);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("run off", q[`ST_RUN], 1'b0);
        apb(1'b1, `ADDR_CTRL, cw(1'b1, 1'b0, `TRIG_CMP, 3'h1, 1'b1));
        pin(1'b1);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("run on", q[`ST_RUN], 1'b1);
        pin(1'b1);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("retrig", q[1:0], 2'b10);
        w(100);
        check("ovf", starts - b, 1);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("run clr", q[`ST_RUN], 1'b0);
        $display("test comparator done");
    endtask
    task t_cmp_retrig;
        int b;
        lat <= 8'h3c;
        b = starts;
        apb(1'b1, `ADDR_STATUS, 32'h8);
        apb(1'b1, `ADDR_CTRL, 32'h0);
        apb(1'b1, `ADDR_CTRL, cw(1'b1, 1'b1, `TRIG_CMP, 3'h2, 1'b1));
        pin(1'b1);
        w(80);
        pin(1'b1);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("edge in conv", q[1:0], 2'b01);
        w(300);
        check("one pair", starts - b, 2);
        pin(1'b1);
        w(300);
        check("two pairs", starts - b, 4);
        check("cmp irq", O_CONVERTER_IRQ_FLAG, 1'b1);
        lat <= 8'h04;
        $display("test comparator retrigger done");
    endtask
    task t_manual;
        int b;
        b = starts;
        apb(1'b1, `ADDR_CTRL, 32'h0001_0000);
        apb(1'b1, `ADDR_CTRL, 32'h0);
        w(20);
        check("manual", starts - b, 1);
        apb(1'b0, `ADDR_RESULT, 32'h0);
        check("reinit sum", q, 32'h0);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        check("reinit n", q[`ST_DONE_HI:`ST_DONE_LO], 5'h00);
        $display("test manual done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        w(16);
        I_RST <= 1'b0;
        t_reset;
        t_groups;
        t_overrun;
        t_two;
        t_cmp;
        t_cmp_retrig;
        t_manual;
        finish_test;
    end
    initial
    begin
        w(20000);
        mismatches++;
        finish_test;
    end
endmodule // testbench
`default_nettype wire
